// ==== bench/rtccal_counter_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtccal_counter_chk
    import rtccal_pkg::*;
#(
    parameter int TICK_DIV = 32768
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // inputs
    input wire logic internal_osc_in,
    input wire logic rtc_clock_source_select,
    input wire logic [1:0] clock_pin_output_select,
    input wire logic load_valid,
    // outputs
    input wire rtccal_time_t cur_time,
    input wire logic second_tick,
    input wire logic clock_pin_out
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic end_day = {cur_time.hours, cur_time.minutes, cur_time.seconds} == 24'h235959;
    // bcd year: even tens need units 0/4/8, odd tens need 2/6
    wire logic leap = cur_time.year[4] ? cur_time.year[3:0] inside {4'h2, 4'h6} :
        cur_time.year[3:0] inside {4'h0, 4'h4, 4'h8};
    wire logic [1:0] sel = clock_pin_output_select;
    sequence s_adv(c);
        second_tick && clk_en && !load_valid && c;
    endsequence
    a_units_carry: assert property (s_adv(cur_time.seconds[3:0] == 4'h9 && cur_time.seconds != 8'h59)
        |=> cur_time.seconds == $past(cur_time.seconds) + 8'h07) else $error("bcd carry wrong");
    a_day_roll: assert property (s_adv(end_day) |=> cur_time[23:0] == 24'h0
        && cur_time.day != $past(cur_time.day)) else $error("day rollover wrong");
    a_wday_wrap: assert property (s_adv(end_day && cur_time.weekday == 3'h6)
        |=> cur_time.weekday == 3'h0) else $error("weekday wrap wrong");
    a_wday_step: assert property (s_adv(end_day && cur_time.weekday < 3'h6)
        |=> cur_time.weekday == $past(cur_time.weekday) + 3'h1) else $error("weekday step wrong");
    a_year_wrap: assert property (s_adv(end_day && cur_time[50:27] == 24'h991231)
        |=> cur_time[50:27] == 24'h000101) else $error("year wrap wrong");
    a_feb_end: assert property (s_adv(end_day && cur_time[42:27] == 16'h0228)
        |=> cur_time.day == ($past(leap) ? 8'h29 : 8'h01)) else $error("february end wrong");
    a_short_month: assert property (s_adv(end_day && cur_time[42:27] == 16'h0430)
        |=> cur_time[42:27] == 16'h0501) else $error("april end wrong");
    a_hold_still: assert property (!clk_en || !second_tick && !load_valid |=> $stable(cur_time))
        else $error("time moved without tick");
    a_pin_low: assert property ((clk_en && (sel != 2'h1 && !(sel == 2'h2 && rtc_clock_source_select)))[*3]
        |-> !clock_pin_out) else $error("pin not low");
    a_pin_osc: assert property ((clk_en && sel == 2'h2 && rtc_clock_source_select && internal_osc_in)[*3]
        |-> clock_pin_out) else $error("pin lacks oscillator");
    // seconds wave on the pin flips one cycle after the tick that toggled it
    a_pin_sec: assert property (second_tick && clk_en && sel == 2'h1 && $past(sel) == 2'h1
        |=> clock_pin_out != $past(clock_pin_out)) else $error("pin seconds wave wrong");
endmodule : rtccal_counter_chk
bind rtccal_counter rtccal_counter_chk #(.TICK_DIV(TICK_DIV)) i_rtccal_counter_chk (.core_clk(core_clk),
    .rst_n(rst_n), .clk_en(clk_en), .internal_osc_in(internal_osc_in),
    .rtc_clock_source_select(rtc_clock_source_select), .clock_pin_output_select(clock_pin_output_select),
    .load_valid(load_valid), .cur_time(cur_time), .second_tick(second_tick), .clock_pin_out(clock_pin_out));
`default_nettype wire

// ==== bench/rtccal_counter_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; $display("BAD %s %h %h", nm, e, s); end end
module rtccal_counter_tb
    import rtccal_pkg::*;
;
    localparam int TICK = 2;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic crystal_osc_in = 1'b0;
    logic internal_osc_in = 1'b0;
    logic rtc_clock_source_select = 1'b0;
    logic [1:0] clock_pin_output_select = 2'h0;
    logic load_valid = 1'b0;
    rtccal_time_t load_time = '0;
    rtccal_time_t cur_time;
    rtccal_time_t exp_t;
    rtccal_time_t exp_q[$];
    logic second_tick;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 48279;
    bit pend = 1'b0;
    always #25 core_clk = ~core_clk;
    rtccal_counter #(.TICK_DIV(TICK)) i_rtccal_counter (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .crystal_osc_in(crystal_osc_in), .internal_osc_in(internal_osc_in),
        .rtc_clock_source_select(rtc_clock_source_select), .clock_pin_output_select(clock_pin_output_select),
        .load_valid(load_valid), .load_time(load_time), .load_ready(), .cur_time(cur_time),
        .second_tick(second_tick), .clock_pin_out());
    function automatic rtccal_time_t mk(input logic [23:0] ymd, input logic [2:0] wd, input logic [23:0] t);
        return {ymd, wd, t};
    endfunction : mk
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // only the selected oscillator toggles; a wrong pick never ticks
    task automatic pulse(input int n);
        repeat (2 * n)
        begin
            if (rtc_clock_source_select)
                internal_osc_in = ~internal_osc_in;
            else
                crystal_osc_in = ~crystal_osc_in;
            repeat (3) @(negedge core_clk);
        end
    endtask : pulse
    task automatic run_case(input logic [2:0] i, input rtccal_time_t t, input rtccal_time_t e);
        logic idle;
        idle = 1'($random(seed));
        @(negedge core_clk);
        rtc_clock_source_select = i[0];
        clock_pin_output_select = i[2:1];
        {internal_osc_in, crystal_osc_in} = i[0] ? {1'b0, idle} : {idle, 1'b0};
        load_valid = 1'b1;
        load_time = t;
        @(negedge core_clk);
        load_valid = 1'b0;
        clk_en = 1'b0;
        repeat (2) @(negedge core_clk);
        clk_en = 1'b1;
        exp_q.push_back(e);
        pulse(TICK - 1);
        repeat (4) @(negedge core_clk);
        `CHK("early", 32'h1, exp_q.size())
        pulse(1);
        repeat (4) @(negedge core_clk);
        `CHK("tick", 32'h0, exp_q.size())
    endtask : run_case
    always @(negedge core_clk)
    begin
        if (pend)
        begin
            exp_t = exp_q.size() ? exp_q.pop_front() : '1;
            `CHK("time", exp_t, cur_time)
        end
        pend = second_tick === 1'b1;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK("reset", mk(24'h000101, 3'h0, 24'h0), cur_time)
        run_case(0, mk(24'h210315, 3'h2, 24'h000009), mk(24'h210315, 3'h2, 24'h000010));
        run_case(1, mk(24'h210315, 3'h2, 24'h005959), mk(24'h210315, 3'h2, 24'h010000));
        run_case(2, mk(24'h210315, 3'h6, 24'h235959), mk(24'h210316, 3'h0, 24'h0));
        run_case(3, mk(24'h991231, 3'h3, 24'h235959), mk(24'h000101, 3'h4, 24'h0));
        run_case(4, mk(24'h240228, 3'h1, 24'h235959), mk(24'h240229, 3'h2, 24'h0));
        run_case(5, mk(24'h230228, 3'h1, 24'h235959), mk(24'h230301, 3'h2, 24'h0));
        run_case(6, mk(24'h000228, 3'h1, 24'h235959), mk(24'h000229, 3'h2, 24'h0));
        run_case(7, mk(24'h120430, 3'h4, 24'h235959), mk(24'h120501, 3'h5, 24'h0));
        run_case(0, mk(24'h120131, 3'h4, 24'h235959), mk(24'h120201, 3'h5, 24'h0));
        run_case(1, mk(24'h240229, 3'h5, 24'h235959), mk(24'h240301, 3'h6, 24'h0));
        run_case(2, mk(24'h100930, 3'h0, 24'h095959), mk(24'h100930, 3'h0, 24'h100000));
        complete_run();
    end
endmodule : rtccal_counter_tb
`default_nettype wire

// ==== src/rtccal_bcd_field.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rtccal_cfg.svh"

module rtccal_bcd_field
    import rtccal_pkg::*;
#(
    parameter rtccal_bcd_t MIN_VAL = 8'h00
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // control
    input wire logic inc,
    input wire rtccal_bcd_t max_val,
    input wire logic load,
    input wire rtccal_bcd_t load_val,
    // result
    output rtccal_bcd_t value,
    output logic carry
);

    rtccal_bcd_t value_q;
    rtccal_bcd_t value_d;
    wire logic at_max;
    wire logic lo_nine;

    assign at_max = (value_q >= max_val);
    assign lo_nine = (value_q[3:0] == 4'h9);
    // the low digit carries at ten, not sixteen
    assign value_d = at_max ? MIN_VAL :
                     lo_nine ? {value_q[7:4] + 4'h1, 4'h0} :
                     {value_q[7:4], value_q[3:0] + 4'h1};
    assign carry = inc & at_max;
    assign value = value_q;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            value_q <= MIN_VAL;
        end
        else if (clk_en)
        begin
            if (load)
            begin
                value_q <= load_val;
            end
            else if (inc)
            begin
                value_q <= value_d;
            end
        end
    end

endmodule : rtccal_bcd_field

`default_nettype wire

// ==== src/rtccal_cfg.svh ====
`ifndef RTCCAL_CFG_SVH
`define RTCCAL_CFG_SVH

// timing
`define RTCCAL_SRC_FREQ_KHZ 32.768
`define RTCCAL_SRC_HZ 32768
`define RTCCAL_CORE_CLK_HZ 20000000
`define RTCCAL_TICK_DIV (`RTCCAL_SRC_HZ)

// clock pin output select codes
`define RTCCAL_PIN_SEL_OFF 2'h0
`define RTCCAL_PIN_SEL_SECONDS 2'h1
`define RTCCAL_PIN_SEL_OSC 2'h2

// clock source select values
`define RTCCAL_SRC_CRYSTAL 1'b0
`define RTCCAL_SRC_INTERNAL 1'b1

// field limits in bcd
`define RTCCAL_SEC_MAX 8'h59
`define RTCCAL_MIN_MAX 8'h59
`define RTCCAL_HOUR_MAX 8'h23
`define RTCCAL_MONTH_MAX 8'h12
`define RTCCAL_YEAR_MAX 8'h99
`define RTCCAL_WDAY_MAX 3'h6
`define RTCCAL_DAY_31 8'h31
`define RTCCAL_DAY_30 8'h30
`define RTCCAL_DAY_29 8'h29
`define RTCCAL_DAY_28 8'h28

// reset values
`define RTCCAL_RST_ZERO 8'h00
`define RTCCAL_RST_ONE 8'h01
`define RTCCAL_RST_WDAY 3'h0

`endif

// ==== src/rtccal_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rtccal_cfg.svh"

// Behaviour
// - counter clock is crystal or internal oscillator, picked by one config bit
// - with internal oscillator selected, output select routes its clock to the pin
// - time of day rolls 23:59:59 to 00:00:00 and bumps the day
// - after December 31 date becomes January 1 and year increments
// - weekday advances each day, wraps 6 to 0 with no carry
// - year wraps 99 to 00 with no further carry
// - all fields but the 3-bit weekday are bcd; low digit carries into high digit at ten
// - weekday codes: Sunday 0 through Saturday 6
// - day limit is 31, 30, or 28/29 depending on month
module rtccal_counter
    import rtccal_pkg::*;
#(
    parameter int TICK_DIV = `RTCCAL_TICK_DIV
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // oscillator inputs, sampled on core_clk
    input wire logic crystal_osc_in,
    input wire logic internal_osc_in,
    // configuration
    input wire logic rtc_clock_source_select,
    input wire logic [1:0] clock_pin_output_select,
    // time load
    input wire logic load_valid,
    input wire rtccal_time_t load_time,
    output logic load_ready,
    // state
    output rtccal_time_t cur_time,
    output logic second_tick,
    output logic clock_pin_out
);

    localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    // february length from a bcd year; tens even means units 0/4/8, odd means 2/6
    function automatic logic leap_year(input rtccal_bcd_t yr);
        logic tens_odd;
        tens_odd = yr[4];
        if (tens_odd)
        begin
            leap_year = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
        end
        else
        begin
            leap_year = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
        end
    endfunction : leap_year

    function automatic rtccal_bcd_t month_last_day(input rtccal_bcd_t mon, input rtccal_bcd_t yr);
        rtccal_bcd_t res;
        res = `RTCCAL_DAY_31;
        if (mon == 8'h02)
        begin
            res = leap_year(yr) ? `RTCCAL_DAY_29 : `RTCCAL_DAY_28;
        end
        else if ((mon == 8'h04) || (mon == 8'h06) || (mon == 8'h09) || (mon == 8'h11))
        begin
            res = `RTCCAL_DAY_30;
        end
        month_last_day = res;
    endfunction : month_last_day

    logic src_q;
    logic [DIV_W-1:0] div_q;
    logic tick_q;
    logic sec_level_q;
    logic pin_q;
    logic [2:0] wday_q;

    wire logic src_sel;
    wire logic src_rise;
    wire logic div_wrap;
    wire logic pin_d;
    wire logic sec_carry;
    wire logic min_carry;
    wire logic hour_carry;
    wire logic day_carry;
    wire logic month_carry;
    wire rtccal_bcd_t day_max;
    wire logic load_now;

    assign src_sel = (rtc_clock_source_select == `RTCCAL_SRC_INTERNAL) ?
                     internal_osc_in : crystal_osc_in;
    // oscillators are far slower than core_clk, so one edge per sample pair is safe
    assign src_rise = src_sel & ~src_q;
    assign div_wrap = src_rise && (div_q == DIV_LAST);

    // internal oscillator reaches the pin only when it clocks the counter
    assign pin_d = (clock_pin_output_select == `RTCCAL_PIN_SEL_OSC) ?
                   (src_sel & (rtc_clock_source_select == `RTCCAL_SRC_INTERNAL)) :
                   (clock_pin_output_select == `RTCCAL_PIN_SEL_SECONDS) ? sec_level_q :
                   1'b0;

    assign load_ready = 1'b1;
    assign load_now = load_valid;
    assign second_tick = tick_q;
    assign clock_pin_out = pin_q;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            src_q <= 1'b0;
            div_q <= '0;
            tick_q <= 1'b0;
            sec_level_q <= 1'b0;
            pin_q <= 1'b0;
        end
        else if (clk_en)
        begin
            src_q <= src_sel;
            pin_q <= pin_d;
            tick_q <= div_wrap;
            if (div_wrap)
            begin
                div_q <= '0;
                sec_level_q <= ~sec_level_q;
            end
            else if (src_rise)
            begin
                div_q <= div_q + DIV_W'(1);
            end
        end
    end

    rtccal_bcd_field #(.MIN_VAL(`RTCCAL_RST_ZERO)) u_seconds (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inc(tick_q),
        .max_val(`RTCCAL_SEC_MAX),
        .load(load_now),
        .load_val(load_time.seconds),
        .value(cur_time.seconds),
        .carry(sec_carry)
    );

    rtccal_bcd_field #(.MIN_VAL(`RTCCAL_RST_ZERO)) u_minutes (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inc(sec_carry),
        .max_val(`RTCCAL_MIN_MAX),
        .load(load_now),
        .load_val(load_time.minutes),
        .value(cur_time.minutes),
        .carry(min_carry)
    );

    // 23:59:59 wraps to midnight and hands one day on
    rtccal_bcd_field #(.MIN_VAL(`RTCCAL_RST_ZERO)) u_hours (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inc(min_carry),
        .max_val(`RTCCAL_HOUR_MAX),
        .load(load_now),
        .load_val(load_time.hours),
        .value(cur_time.hours),
        .carry(hour_carry)
    );

    assign day_max = month_last_day(cur_time.month, cur_time.year);

    rtccal_bcd_field #(.MIN_VAL(`RTCCAL_RST_ONE)) u_day (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inc(hour_carry),
        .max_val(day_max),
        .load(load_now),
        .load_val(load_time.day),
        .value(cur_time.day),
        .carry(day_carry)
    );

    // 12/31 goes to 01/01 and the month wrap feeds the year
    rtccal_bcd_field #(.MIN_VAL(`RTCCAL_RST_ONE)) u_month (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inc(day_carry),
        .max_val(`RTCCAL_MONTH_MAX),
        .load(load_now),
        .load_val(load_time.month),
        .value(cur_time.month),
        .carry(month_carry)
    );

    // year carry out is dropped: 99 back to 00 ends the usable range
    rtccal_bcd_field #(.MIN_VAL(`RTCCAL_RST_ZERO)) u_year (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .inc(month_carry),
        .max_val(`RTCCAL_YEAR_MAX),
        .load(load_now),
        .load_val(load_time.year),
        .value(cur_time.year),
        .carry()
    );

    // weekday: 0 is Sunday, 6 is Saturday, wraps with no carry
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wday_q <= `RTCCAL_RST_WDAY;
        end
        else if (clk_en)
        begin
            if (load_now)
            begin
                wday_q <= load_time.weekday;
            end
            else if (hour_carry)
            begin
                wday_q <= (wday_q >= `RTCCAL_WDAY_MAX) ? 3'h0 : wday_q + 3'h1;
            end
        end
    end

    assign cur_time.weekday = wday_q;

endmodule : rtccal_counter

`default_nettype wire

// ==== src/rtccal_pkg.sv ====
`default_nettype none
package rtccal_pkg;

    typedef logic [7:0] rtccal_bcd_t;

    typedef struct packed {
        rtccal_bcd_t year;
        rtccal_bcd_t month;
        rtccal_bcd_t day;
        logic [2:0] weekday;
        rtccal_bcd_t hours;
        rtccal_bcd_t minutes;
        rtccal_bcd_t seconds;
    } rtccal_time_t;

endpackage : rtccal_pkg
`default_nettype wire
